/* File: design/asrc_ctrl.sv */
// host-side controller that drives the 64K x 16 asynchronous static memory pins
`timescale 1ns/100ps
module asrc_ctrl (
  input  wire logic               i_mclk,
  input  wire logic               i_reset_n,
  input  wire logic               i_req_valid,
  input  wire asrc_pkg::asrc_req_t i_req,
  output logic                    o_req_ready,
  output logic                    o_rd_valid,
  output logic [15:0]             o_rd_data,
  output asrc_pkg::asrc_ctl_t     o_ctl,
  output logic [15:0]             o_addr,
  output logic [15:0]             o_dq_out,
  output logic [15:0]             o_dq_oe,
  input  wire logic [15:0]        i_dq_in
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b011,
    ST_HOLD  = 3'b100,
    ST_TURN  = 3'b101
  } asrc_state_t;

  localparam logic [4:0] RD_N   = 5'(asrc_pkg::RD_CYC);
  localparam logic [4:0] WR_N   = 5'(asrc_pkg::WR_CYC);
  localparam logic [4:0] TURN_N = 5'(asrc_pkg::TURN_CYC);

  asrc_state_t         state_q, state_d;
  logic [4:0]          cnt_q, cnt_d;
  asrc_pkg::asrc_req_t req_q, req_d;
  asrc_pkg::asrc_ctl_t ctl_q, ctl_d;
  logic [15:0]         dq_oe_q, dq_oe_d;
  logic [15:0]         rdat_q, rdat_d;
  logic                rvld_q, rvld_d;
  logic                rdy_q, rdy_d;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    req_d   = req_q;
    ctl_d   = ctl_q;
    dq_oe_d = dq_oe_q;
    rdat_d  = rdat_q;
    rvld_d  = 1'b0;
    rdy_d   = 1'b0;
    case (state_q)
      ST_IDLE: begin
        ctl_d   = '1;
        dq_oe_d = '0;
        rdy_d   = 1'b1;
        if (i_req_valid && rdy_q) begin
          // address latched and driven a cycle before any strobe falls
          req_d   = i_req;
          rdy_d   = 1'b0;
          state_d = ST_SETUP;
        end
      end
      ST_SETUP: begin
        cnt_d = '0;
        ctl_d.chip_select_n       = 1'b0;
        ctl_d.upper_byte_enable_n = ~req_q.byte_en[1];
        ctl_d.lower_byte_enable_n = ~req_q.byte_en[0];
        if (req_q.write) begin
          // all strobes fall together so the write starts at one edge
          // with no lane enabled the strobe stays high: no write is begun on a bare select
          ctl_d.write_strobe_n  = ~|req_q.byte_en;
          ctl_d.output_enable_n = 1'b1;
          // only the enabled lanes are driven
          dq_oe_d = {{8{req_q.byte_en[1]}}, {8{req_q.byte_en[0]}}};
          state_d = ST_WRITE;
        end else begin
          // strobe held high across the whole read
          ctl_d.write_strobe_n  = 1'b1;
          ctl_d.output_enable_n = 1'b0;
          dq_oe_d = '0;
          state_d = ST_READ;
        end
      end
      ST_READ: begin
        cnt_d = cnt_q + 5'h01;
        if (cnt_q == RD_N - 5'h01) begin
          // capture only enabled lanes; others read as zero
          rdat_d = i_dq_in & {{8{req_q.byte_en[1]}}, {8{req_q.byte_en[0]}}};
          rvld_d = 1'b1;
          ctl_d  = '1;
          cnt_d  = '0;
          // memory may still drive for the float time; wait before next request
          state_d = ST_TURN;
        end
      end
      ST_WRITE: begin
        cnt_d = cnt_q + 5'h01;
        if (cnt_q == WR_N - 5'h01) begin
          // write strobe ends the write; data stays one more cycle
          ctl_d.write_strobe_n = 1'b1;
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // select and byte enables rise after strobe, never together with it
        ctl_d   = '1;
        dq_oe_d = '0;
        cnt_d   = '0;
        state_d = ST_TURN;
      end
      ST_TURN: begin
        cnt_d = cnt_q + 5'h01;
        if (cnt_q == TURN_N - 5'h01) begin
          cnt_d   = '0;
          rdy_d   = 1'b1;
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        ctl_d   = '1;
        dq_oe_d = '0;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
      req_q   <= '0;
      ctl_q   <= '1;
      dq_oe_q <= '0;
      rdat_q  <= '0;
      rvld_q  <= 1'b0;
      rdy_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      req_q   <= req_d;
      ctl_q   <= ctl_d;
      dq_oe_q <= dq_oe_d;
      rdat_q  <= rdat_d;
      rvld_q  <= rvld_d;
      rdy_q   <= rdy_d;
    end
  end

  assign o_req_ready = rdy_q;
  assign o_rd_valid  = rvld_q;
  assign o_rd_data   = rdat_q;
  assign o_ctl       = ctl_q;
  assign o_addr      = req_q.addr;
  assign o_dq_out    = req_q.wdata;
  assign o_dq_oe     = dq_oe_q;

  // helper: cycles since select fell
  logic [5:0] sel_cnt_q;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_cnt_q <= '0;
    end else begin
      sel_cnt_q <= ctl_q.chip_select_n ? 6'h00 : sel_cnt_q + 6'h01;
    end
  end

  // helper: cycles the write strobe has been low; a counter keeps the width check cheap
  logic [4:0] we_low_cnt_q, we_low_cnt_d;
  always_comb begin
    we_low_cnt_d = ctl_q.write_strobe_n ? 5'h00 : we_low_cnt_q + 5'h01;
  end
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      we_low_cnt_q <= '0;
    end else begin
      we_low_cnt_q <= we_low_cnt_d;
    end
  end

  sequence s_wr_open;
    !ctl_q.chip_select_n && !ctl_q.write_strobe_n;
  endsequence
  sequence s_wr_close;
    ctl_q.write_strobe_n && !ctl_q.chip_select_n;
  endsequence

  AST_WRITE_NEEDS_SELECT: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !ctl_q.write_strobe_n |-> !ctl_q.chip_select_n && ctl_q.output_enable_n)
    else $error("write strobe low without select");
  AST_READ_STROBE_HIGH: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !ctl_q.output_enable_n |-> ctl_q.write_strobe_n)
    else $error("write strobe low during read");
  AST_NO_DRIVE_ON_READ: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (!ctl_q.output_enable_n || state_q == ST_TURN) |-> dq_oe_q == 16'h0000)
    else $error("host drives bus while memory may drive");
  AST_LANES_MATCH: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !ctl_q.write_strobe_n |-> dq_oe_q == {{8{!ctl_q.upper_byte_enable_n}}, {8{!ctl_q.lower_byte_enable_n}}})
    else $error("driven lanes differ from byte enables");
  AST_WRITE_START: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $fell(ctl_q.write_strobe_n) |-> $fell(ctl_q.chip_select_n) &&
      (!ctl_q.upper_byte_enable_n || !ctl_q.lower_byte_enable_n))
    else $error("write start not aligned with select");
  AST_WRITE_HOLD: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_wr_open ##1 s_wr_close |-> $stable(o_dq_out) && dq_oe_q != 16'h0000 ##1 ctl_q.chip_select_n)
    else $error("write data not held past strobe rise");
  AST_NO_JOINT_RISE: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $rose(ctl_q.write_strobe_n) |-> !ctl_q.chip_select_n)
    else $error("select rose with write strobe");
  AST_ADDR_STABLE: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !ctl_q.chip_select_n |-> $stable(o_addr))
    else $error("address moved while selected");
  AST_WRITE_WIDTH: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $rose(ctl_q.write_strobe_n) |-> we_low_cnt_q == WR_N)
    else $error("write pulse width wrong");
  AST_WRITE_NOT_LONG: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !ctl_q.write_strobe_n |-> we_low_cnt_q < WR_N)
    else $error("write pulse too long");
  AST_READ_LEN: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $rose(o_rd_valid) |-> sel_cnt_q == {1'b0, RD_N} && $past(sel_cnt_q) == {1'b0, RD_N - 5'h01})
    else $error("read strobe length wrong");
endmodule

/* File: design/asrc_pkg.sv */
// package: pin timing counts and request/pin carriers for the static memory controller
package asrc_pkg;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  // least times in ps, rounded up to whole cycles below
  localparam int unsigned T_RC_PS  = 55000;
  localparam int unsigned T_AA_PS  = 55000;
  localparam int unsigned T_WC_PS  = 55000;
  localparam int unsigned T_PWE_PS = 50000;
  localparam int unsigned T_HZ_PS  = 20000;
  localparam int unsigned RD_CYC   = (T_AA_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WR_CYC   = (T_PWE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned TURN_CYC = (T_HZ_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CYC_RC   = (T_RC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CYC_WC   = (T_WC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W    = 5;
  localparam int unsigned ADDR_W   = 16;
  localparam int unsigned DATA_W   = 16;

  typedef struct packed {
    logic              write;
    logic [1:0]        byte_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asrc_req_t;

  typedef struct packed {
    logic              chip_select_n;
    logic              write_strobe_n;
    logic              output_enable_n;
    logic              upper_byte_enable_n;
    logic              lower_byte_enable_n;
  } asrc_ctl_t;
endpackage

/* File: verification/asrc_sram_model.sv */
// behavioural 64K x 16 static memory as seen on the controller's pins
`timescale 1ns/100ps
module asrc_sram_model (
  input  wire asrc_pkg::asrc_ctl_t i_ctl,
  input  wire logic [15:0]         i_addr,
  input  wire logic [15:0]         i_dq,
  output logic [15:0]              o_dq,
  output logic [15:0]              o_dq_oe
);
  logic [15:0] mem [0:65535];
  logic        wr;
  logic        rd;
  // no clock: modes follow the pin levels alone
  assign wr = !i_ctl.chip_select_n && !i_ctl.write_strobe_n;
  assign rd = !i_ctl.chip_select_n && i_ctl.write_strobe_n && !i_ctl.output_enable_n;
  assign o_dq_oe = {{8{rd && !i_ctl.upper_byte_enable_n}}, {8{rd && !i_ctl.lower_byte_enable_n}}};
  assign o_dq = mem[i_addr];
  always @* begin
    if (wr && !i_ctl.lower_byte_enable_n) mem[i_addr][7:0] = i_dq[7:0];
    if (wr && !i_ctl.upper_byte_enable_n) mem[i_addr][15:8] = i_dq[15:8];
  end
endmodule

/* File: verification/tb_asrc_ctrl.sv */
// self-checking bench: controller against the behavioural memory
`timescale 1ns/100ps
module tb_asrc_ctrl;
  logic                i_mclk      = 1'b0;
  logic                i_reset_n   = 1'b0;
  logic                i_req_valid = 1'b0;
  asrc_pkg::asrc_req_t i_req       = '0;
  logic                o_req_ready;
  logic                o_rd_valid;
  logic [15:0]         o_rd_data;
  asrc_pkg::asrc_ctl_t o_ctl;
  logic [15:0]         o_addr;
  logic [15:0]         o_dq_out;
  logic [15:0]         o_dq_oe;
  logic [15:0]         mem_dq;
  logic [15:0]         mem_oe;
  logic [15:0]         bus;
  logic [15:0]         bus_q       = 16'h0000;
  logic [15:0]         q;
  int                  mismatches  = 0;
  int                  check_count = 0;

  asrc_ctrl i_asrc_ctrl (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_req_valid(i_req_valid), .i_req(i_req),
    .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_ctl(o_ctl),
    .o_addr(o_addr), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .i_dq_in(bus));
  asrc_sram_model i_asrc_sram_model (.i_ctl(o_ctl), .i_addr(o_addr), .i_dq(bus), .o_dq(mem_dq), .o_dq_oe(mem_oe));

  always #2.5 i_mclk = ~i_mclk;
  // an undriven line shows the inverse of its last level so a float never reads as good data
  always_comb for (int b = 0; b < 16; b++) bus[b] = o_dq_oe[b] ? o_dq_out[b] : (mem_oe[b] ? mem_dq[b] : ~bus_q[b]);
  always @(posedge i_mclk) bus_q <= bus;

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  always @(negedge i_mclk) if (i_reset_n) check(o_dq_oe & mem_oe, 16'h0000);

  task automatic access(input logic wr, input logic [1:0] be, input logic [15:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge i_mclk);
    while (o_req_ready !== 1'b1 && n < 100) begin
      @(negedge i_mclk);
      n++;
    end
    i_req_valid = 1'b1;
    i_req = '{wr, be, a, d};
    @(negedge i_mclk);
    i_req_valid = 1'b0;
    n = 0;
    if (!wr) begin
      while (o_rd_valid !== 1'b1 && n < 100) begin
        @(negedge i_mclk);
        n++;
      end
      q = o_rd_data;
      check(16'(n), 16'h000C);
    end
  endtask

  task automatic t_reset();
    check({11'h000, o_ctl}, 16'h001F);
    check(o_dq_oe, 16'h0000);
  endtask

  task automatic t_word();
    access(1'b1, 2'h3, 16'hFFFF, 16'h1234);
    access(1'b1, 2'h3, 16'h0000, 16'hC3A5);
    access(1'b0, 2'h3, 16'hFFFF, 16'h0000);
    check(q, 16'h1234);
    access(1'b0, 2'h3, 16'h0000, 16'h0000);
    check(q, 16'hC3A5);
  endtask

  task automatic t_bytes();
    access(1'b1, 2'h1, 16'hFFFF, 16'hABCD);
    access(1'b1, 2'h2, 16'hFFFF, 16'hEF77);
    access(1'b1, 2'h0, 16'hFFFF, 16'h0000);
    access(1'b0, 2'h3, 16'hFFFF, 16'h0000);
    check(q, 16'hEFCD);
    access(1'b0, 2'h1, 16'hFFFF, 16'h0000);
    check(q, 16'h00CD);
    access(1'b0, 2'h2, 16'hFFFF, 16'h0000);
    check(q, 16'hEF00);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (2) @(negedge i_mclk);
    t_reset();
    i_reset_n = 1'b1;
    t_word();
    t_bytes();
    report_and_stop();
  end

  // ten accesses of about twenty cycles each fit well inside this span
  initial begin
    #5000;
    mismatches++;
    report_and_stop();
  end
endmodule
